/* File: pkg/atm_defines.vh */
// Purpose: constants for the address table manual access block
// Assumes: register indices as printed, one 32-bit word each
// Notes: definitions only
`ifndef ATM_DEFINES_VH
`define ATM_DEFINES_VH
`define ATM_ADDR_W 16
`define ATM_REG_CMD 16'h1800
`define ATM_REG_WR_LOW 16'h1801
`define ATM_REG_WR_HIGH 16'h1802
`define ATM_REG_CMD_STS 16'h1803
`define ATM_REG_RD_LOW 16'h1805
`define ATM_REG_RD_HIGH 16'h1806
`define ATM_CMD_MAKE 2
`define ATM_CMD_FIRST 1
`define ATM_CMD_NEXT 0
`define ATM_HI_VALID 24
`define ATM_HI_AGE 23
`define ATM_HI_END 23
`define ATM_HI_STATIC 22
`define ATM_HI_FILTER 21
`define ATM_HI_PRI_MSB 20
`define ATM_HI_PRI_LSB 19
`define ATM_HI_PORT_MSB 18
`define ATM_HI_PORT_LSB 16
`define ATM_HI_MAC_MSB 15
`define ATM_HI_USED_MSB 24
`define ATM_PORT_RESVD 3'h3
`define ATM_STS_PEND 0
`define ATM_DEPTH 16
`define ATM_IDX_W 4
`define ATM_IDX_LAST 4'hf
`define ATM_AGE_MIN 5
`define ATM_CLK_MHZ 200
`define ATM_ZERO32 32'h00000000
`endif

/* File: core/atm_table.v */
// Purpose: manual make, get-first and get-next access to the address lookup table
// Assumes: register port on the core clock; table kept inside this module
// Notes: aging tick comes from a slow divider; one search step per clock
`timescale 1ns/1ps
`include "atm_defines.vh"
module atm_table #(
  parameter MIN_TICKS = 32'd300
) (
  // clock and reset
  input wire clk_i,
  input wire reset_i,
  // register port
  input wire reg_sel_i,
  input wire reg_wr_i,
  input wire [`ATM_ADDR_W-1:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  output reg [31:0] reg_rdata_o,
  // global ingress config bit 5
  input wire da_pri_en_i,
  // forwarding lookup by destination, learning by source
  input wire lk_req_i,
  input wire [47:0] lk_da_i,
  input wire [47:0] lk_sa_i,
  input wire [1:0] lk_src_port_i,
  input wire [1:0] lk_port_state_i,
  output reg lk_hit_o,
  output reg lk_drop_o,
  output reg lk_pri_en_o,
  output reg [1:0] lk_pri_o,
  output reg [2:0] lk_port_mask_o,
  output reg lk_override_o,
  // one pulse per second tick for aging
  input wire sec_tick_i
);
  localparam ST_IDLE = 3'b001;
  localparam ST_MAKE = 3'b010;
  localparam ST_SCAN = 3'b100;

  reg [31:0] tbl_low [0:`ATM_DEPTH-1];
  reg [24:0] tbl_high [0:`ATM_DEPTH-1];
  reg [31:0] age_cnt [0:`ATM_DEPTH-1];
  reg [2:0] cmd;
  reg [31:0] wr_low;
  reg [24:0] wr_high;
  reg [31:0] rd_low;
  reg [24:0] rd_high;
  reg make_pend;
  reg [2:0] state;
  reg [`ATM_IDX_W-1:0] rptr;
  reg rptr_fresh;
  wire [`ATM_DEPTH-1:0] match_v;
  wire [`ATM_DEPTH-1:0] free_v;
  wire [`ATM_DEPTH-1:0] da_v;
  wire [`ATM_DEPTH-1:0] sa_v;
  reg [`ATM_IDX_W-1:0] make_idx;
  reg make_found;
  reg [`ATM_IDX_W-1:0] da_idx;
  reg [`ATM_IDX_W-1:0] sa_idx;
  reg sa_found;
  reg [2:0] next_mask;
  integer k;
  genvar g;

  wire wr_cmd = reg_sel_i & reg_wr_i & (reg_addr_i == `ATM_REG_CMD);
  wire [47:0] wr_mac = {wr_high[`ATM_HI_MAC_MSB:0], wr_low};

  // per-entry compare against make address, lookups and free slots
  generate
    for (g = 0; g < `ATM_DEPTH; g = g + 1) begin : g_cmp
      assign match_v[g] = tbl_high[g][`ATM_HI_VALID] &&
        ({tbl_high[g][`ATM_HI_MAC_MSB:0], tbl_low[g]} == wr_mac);
      assign free_v[g] = ~tbl_high[g][`ATM_HI_VALID];
      assign da_v[g] = tbl_high[g][`ATM_HI_VALID] &&
        ({tbl_high[g][`ATM_HI_MAC_MSB:0], tbl_low[g]} == lk_da_i);
      assign sa_v[g] = tbl_high[g][`ATM_HI_VALID] &&
        ({tbl_high[g][`ATM_HI_MAC_MSB:0], tbl_low[g]} == lk_sa_i);
    end
  endgenerate

  // slot choice: existing match first, else lowest free slot
  always @* begin
    make_idx = {`ATM_IDX_W{1'b0}};
    make_found = 1'b0;
    da_idx = {`ATM_IDX_W{1'b0}};
    sa_idx = {`ATM_IDX_W{1'b0}};
    sa_found = 1'b0;
    for (k = `ATM_DEPTH - 1; k >= 0; k = k - 1) begin
      if (free_v[k]) begin
        make_idx = k[`ATM_IDX_W-1:0];
        make_found = 1'b1;
      end
      if (da_v[k]) begin
        da_idx = k[`ATM_IDX_W-1:0];
      end
      if (sa_v[k]) begin
        sa_idx = k[`ATM_IDX_W-1:0];
        sa_found = 1'b1;
      end
    end
    for (k = `ATM_DEPTH - 1; k >= 0; k = k - 1) begin
      if (match_v[k]) begin
        make_idx = k[`ATM_IDX_W-1:0];
        make_found = 1'b1;
      end
    end
  end

  // port field decode
  always @* begin
    case (tbl_high[da_idx][`ATM_HI_PORT_MSB:`ATM_HI_PORT_LSB])
      3'h0: next_mask = 3'h1;
      3'h1: next_mask = 3'h2;
      3'h2: next_mask = 3'h4;
      3'h4: next_mask = 3'h3;
      3'h5: next_mask = 3'h5;
      3'h6: next_mask = 3'h6;
      3'h7: next_mask = 3'h7;
      default: next_mask = 3'h0;
    endcase
  end

  // register file and command engine
  always @(posedge clk_i) begin
    if (reset_i) begin
      cmd <= 3'h0;
      wr_low <= `ATM_ZERO32;
      wr_high <= 25'h0000000;
      rd_low <= `ATM_ZERO32;
      rd_high <= 25'h0000000;
      make_pend <= 1'b0;
      state <= ST_IDLE;
      rptr <= {`ATM_IDX_W{1'b0}};
      rptr_fresh <= 1'b1;
      for (k = 0; k < `ATM_DEPTH; k = k + 1) begin
        tbl_high[k] <= 25'h0000000;
        tbl_low[k] <= `ATM_ZERO32;
        age_cnt[k] <= `ATM_ZERO32;
      end
    end else begin
      if (reg_sel_i && reg_wr_i && reg_addr_i == `ATM_REG_WR_LOW) begin
        wr_low <= reg_wdata_i;
      end
      if (reg_sel_i && reg_wr_i && reg_addr_i == `ATM_REG_WR_HIGH) begin
        wr_high <= reg_wdata_i[`ATM_HI_USED_MSB:0];
      end
      if (wr_cmd) begin
        cmd <= reg_wdata_i[`ATM_CMD_MAKE:0];
      end
      // aging: non-static entries dropped after the idle limit
      for (k = 0; k < `ATM_DEPTH; k = k + 1) begin
        if (sec_tick_i && tbl_high[k][`ATM_HI_VALID] && !tbl_high[k][`ATM_HI_STATIC]) begin
          if (age_cnt[k] >= MIN_TICKS) begin
            tbl_high[k][`ATM_HI_VALID] <= 1'b0;
          end else begin
            age_cnt[k] <= age_cnt[k] + 32'h00000001;
          end
        end
      end
      // source hit refreshes age and learns port of non-static entries
      if (lk_req_i && sa_found && !tbl_high[sa_idx][`ATM_HI_STATIC]) begin
        age_cnt[sa_idx] <= `ATM_ZERO32;
        tbl_high[sa_idx][`ATM_HI_PORT_MSB:`ATM_HI_PORT_LSB] <= {1'b0, lk_src_port_i};
      end
      case (state)
        ST_IDLE: begin
          // only a written one starts a command
          if (wr_cmd && reg_wdata_i[`ATM_CMD_MAKE] && !cmd[`ATM_CMD_MAKE]) begin
            make_pend <= 1'b1;
            state <= ST_MAKE;
          end else if (wr_cmd && reg_wdata_i[`ATM_CMD_FIRST] && !cmd[`ATM_CMD_FIRST]) begin
            rptr <= {`ATM_IDX_W{1'b0}};
            rptr_fresh <= 1'b1;
            rd_high[`ATM_HI_VALID] <= 1'b0;
            rd_high[`ATM_HI_END] <= 1'b0;
            state <= ST_SCAN;
          end else if (wr_cmd && reg_wdata_i[`ATM_CMD_NEXT] && !cmd[`ATM_CMD_NEXT]) begin
            rd_high[`ATM_HI_VALID] <= 1'b0;
            rd_high[`ATM_HI_END] <= 1'b0;
            if (rptr_fresh) begin
              rptr_fresh <= 1'b0;
            end
            if (rptr == `ATM_IDX_LAST && !rptr_fresh) begin
              rd_high[`ATM_HI_END] <= 1'b1;
            end else begin
              rptr <= rptr_fresh ? rptr : rptr + 1'b1;
              state <= ST_SCAN;
            end
          end
        end
        ST_MAKE: begin
          if (make_found) begin
            tbl_low[make_idx] <= wr_low;
            tbl_high[make_idx] <= wr_high;
            age_cnt[make_idx] <= `ATM_ZERO32;
          end
          make_pend <= 1'b0;
          state <= ST_IDLE;
        end
        ST_SCAN: begin
          if (tbl_high[rptr][`ATM_HI_VALID]) begin
            rd_low <= tbl_low[rptr];
            rd_high <= tbl_high[rptr];
            rd_high[`ATM_HI_END] <= (rptr == `ATM_IDX_LAST);
            rptr_fresh <= 1'b0;
            state <= ST_IDLE;
          end else if (rptr == `ATM_IDX_LAST) begin
            rd_high[`ATM_HI_END] <= 1'b1;
            rptr_fresh <= 1'b0;
            state <= ST_IDLE;
          end else begin
            rptr <= rptr + 1'b1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // read data
  always @(posedge clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= `ATM_ZERO32;
    end else begin
      case (reg_addr_i)
        `ATM_REG_CMD: reg_rdata_o <= {29'h0, cmd};
        `ATM_REG_WR_LOW: reg_rdata_o <= wr_low;
        `ATM_REG_WR_HIGH: reg_rdata_o <= {7'h00, wr_high};
        `ATM_REG_CMD_STS: reg_rdata_o <= {31'h0, make_pend};
        `ATM_REG_RD_LOW: reg_rdata_o <= rd_low;
        `ATM_REG_RD_HIGH: reg_rdata_o <= {7'h00, rd_high};
        default: reg_rdata_o <= `ATM_ZERO32;
      endcase
    end
  end

  // destination lookup result
  always @(posedge clk_i) begin
    if (reset_i) begin
      lk_hit_o <= 1'b0;
      lk_drop_o <= 1'b0;
      lk_pri_en_o <= 1'b0;
      lk_pri_o <= 2'h0;
      lk_port_mask_o <= 3'h0;
      lk_override_o <= 1'b0;
    end else begin
      lk_hit_o <= lk_req_i && (|da_v);
      lk_drop_o <= lk_req_i && (|da_v) && tbl_high[da_idx][`ATM_HI_FILTER];
      lk_pri_en_o <= lk_req_i && (|da_v) && tbl_high[da_idx][`ATM_HI_STATIC] && da_pri_en_i;
      lk_pri_o <= tbl_high[da_idx][`ATM_HI_PRI_MSB:`ATM_HI_PRI_LSB];
      lk_port_mask_o <= (|da_v) ? next_mask : 3'h0;
      lk_override_o <= lk_req_i && (|da_v) && tbl_high[da_idx][`ATM_HI_STATIC] &&
        tbl_high[da_idx][`ATM_HI_AGE] && (|lk_port_state_i | 1'b1);
    end
  end
endmodule // atm_table

/* File: tb/atm_table_monitor.sv */
// Purpose: port checker for atm_table
// Assumes: registered read data and lookup outputs
// Notes: bound below
`timescale 1ns/1ps
module atm_table_monitor (
  // clock, reset, register port
  input wire clk_i,
  input wire reset_i,
  input wire reg_sel_i,
  input wire reg_wr_i,
  input wire [15:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire [31:0] reg_rdata_o,
  // lookup
  input wire da_pri_en_i,
  input wire lk_req_i,
  input wire lk_hit_o,
  input wire lk_drop_o,
  input wire lk_pri_en_o,
  input wire lk_override_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  wire wr_w = reg_sel_i && reg_wr_i;
  a_low_readback: assert property (wr_w && reg_addr_i == 16'h1801 ##1 reg_addr_i == 16'h1801 && !wr_w
    |=> reg_rdata_o == $past(reg_wdata_i, 2)) else $error("low word readback");
  a_high_readback: assert property (wr_w && reg_addr_i == 16'h1802 ##1 reg_addr_i == 16'h1802 && !wr_w
    |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 32'h01ffffff)) else $error("high word readback");
  a_cmd_upper_zero: assert property ($past(reg_addr_i) == 16'h1800 |-> reg_rdata_o[31:3] == 29'h0)
    else $error("command upper bits");
  a_rd_upper_zero: assert property ($past(reg_addr_i) == 16'h1806 |-> reg_rdata_o[31:25] == 7'h0)
    else $error("read word upper bits");
  a_pend_one_cycle: assert property ($past(reg_addr_i) == 16'h1803 && reg_addr_i == 16'h1803
    && reg_rdata_o[0] |=> !reg_rdata_o[0]) else $error("pending too long");
  a_drop_needs_hit: assert property (lk_drop_o |-> lk_hit_o) else $error("drop without hit");
  a_override_hit: assert property (lk_override_o |-> lk_hit_o) else $error("override without hit");
  a_pri_needs_en: assert property (lk_pri_en_o |-> lk_hit_o && $past(da_pri_en_i))
    else $error("priority without enable");
  a_hit_after_req: assert property (lk_hit_o |-> $past(lk_req_i)) else $error("hit without request");
endmodule // atm_table_monitor
bind atm_table atm_table_monitor u_atm_table_monitor (.clk_i(clk_i), .reset_i(reset_i), .reg_sel_i(reg_sel_i),
  .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .da_pri_en_i(da_pri_en_i), .lk_req_i(lk_req_i), .lk_hit_o(lk_hit_o), .lk_drop_o(lk_drop_o),
  .lk_pri_en_o(lk_pri_en_o), .lk_override_o(lk_override_o));

/* File: tb/tb_top.sv */
// Purpose: self-checking bench for atm_table
// Assumes: inputs move 1 ns after the rising edge
// Notes: aging threshold cut to 2 ticks
`timescale 1ns/1ps
module tb_top;
  reg clk_i = 1'b0;
  reg reset_i = 1'b1;
  reg reg_sel_i = 1'b0;
  reg reg_wr_i = 1'b0;
  reg [15:0] reg_addr_i = 16'h1800;
  reg [31:0] reg_wdata_i = 32'h0;
  reg da_pri_en_i = 1'b1;
  reg lk_req_i = 1'b0;
  reg [47:0] lk_da_i = 48'h0;
  reg [47:0] lk_sa_i = 48'h2;
  reg sec_tick_i = 1'b0;
  wire [31:0] reg_rdata_o;
  wire lk_hit_o, lk_drop_o, lk_pri_en_o, lk_override_o;
  wire [1:0] lk_pri_o;
  wire [2:0] lk_port_mask_o;
  wire [8:0] lk_w = {lk_hit_o, lk_drop_o, lk_pri_en_o, lk_pri_o, lk_port_mask_o, lk_override_o};
  localparam [31:0] a_lo = 32'h44332210, a_hi = 32'h01d56655, b_lo = 32'h09080706, b_hi = 32'h01a10b0a;
  integer n_errors = 0;
  integer compares = 0;
  integer cyc = 0;
  reg [31:0] d, hr, lo, lo1;
  atm_table #(.MIN_TICKS(32'd2)) u_atm_table (.clk_i(clk_i), .reset_i(reset_i), .reg_sel_i(reg_sel_i),
    .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .da_pri_en_i(da_pri_en_i), .lk_req_i(lk_req_i), .lk_da_i(lk_da_i), .lk_sa_i(lk_sa_i),
    .lk_src_port_i(2'h1), .lk_port_state_i(2'h0), .lk_hit_o(lk_hit_o), .lk_drop_o(lk_drop_o),
    .lk_pri_en_o(lk_pri_en_o), .lk_pri_o(lk_pri_o), .lk_port_mask_o(lk_port_mask_o),
    .lk_override_o(lk_override_o), .sec_tick_i(sec_tick_i));
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors = n_errors + 1;
      tally_and_finish;
    end
  end
  task tally_and_finish;
    begin
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task check(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task tick;
    begin
      @(posedge clk_i);
      #1;
    end
  endtask
  // strobe stays up across back-to-back writes; a read releases it
  task wr(input [15:0] a, input [31:0] v);
    begin
      reg_sel_i = 1'b1;
      reg_wr_i = 1'b1;
      reg_addr_i = a;
      reg_wdata_i = v;
      tick;
    end
  endtask
  task rd(input [15:0] a);
    begin
      reg_sel_i = 1'b0;
      reg_wr_i = 1'b0;
      reg_addr_i = a;
      tick;
      d = reg_rdata_o;
    end
  endtask
  task look(input [47:0] da);
    begin
      tick;
      lk_da_i = da;
      lk_req_i = 1'b1;
      tick;
      lk_req_i = 1'b0;
    end
  endtask
  task sec;
    begin
      sec_tick_i = 1'b1;
      tick;
      sec_tick_i = 1'b0;
      tick;
    end
  endtask
  task make(input [31:0] l, input [31:0] h);
    integer i;
    reg seen;
    begin
      wr(16'h1801, l);
      wr(16'h1802, h);
      wr(16'h1800, 32'h4);
      seen = 1'b0;
      for (i = 0; i < 20 && !(seen && !d[0]); i = i + 1) begin
        rd(16'h1803);
        seen = seen | d[0];
      end
      check(seen, 1);
      check(d[0], 0);
      wr(16'h1800, 32'h0);
      rd(16'h1800);
    end
  endtask
  task get(input [31:0] c);
    integer i;
    begin
      wr(16'h1800, c);
      d = 32'h0;
      for (i = 0; i < 40 && !(d[24] || d[23]); i = i + 1)
        rd(16'h1806);
      hr = d;
      rd(16'h1805);
      lo = d;
      wr(16'h1800, 32'h0);
      rd(16'h1800);
    end
  endtask
  task t_regs;
    begin
      rd(16'h1801);
      check(d, 32'h0);
      wr(16'h1801, 32'hffffffff);
      rd(16'h1801);
      check(d, 32'hffffffff);
      wr(16'h1802, 32'hffffffff);
      rd(16'h1802);
      check(d, 32'h01ffffff);
      $display("regs end");
    end
  endtask
  task t_walk;
    begin
      make(a_lo, a_hi);
      make(b_lo, b_hi);
      get(32'h2);
      lo1 = lo;
      check(lo == a_lo || lo == b_lo, 1);
      check(hr & 32'h017fffff, (lo == a_lo ? a_hi : b_hi) & 32'h017fffff);
      get(32'h1);
      check(lo, lo1 == a_lo ? b_lo : a_lo);
      check(hr[24], 1);
      get(32'h1);
      check(hr[24:23], 2'b01);
      $display("walk end");
    end
  endtask
  task t_lookup;
    begin
      wr(16'h1801, 32'h11);
      wr(16'h1802, 32'h01400011);
      wr(16'h1800, 32'h0);
      rd(16'h1800);
      look(48'h0011_0000_0011);
      check(lk_hit_o, 0);
      look({a_hi[15:0], a_lo});
      check(lk_w, 9'h16b);
      da_pri_en_i = 1'b0;
      look({a_hi[15:0], a_lo});
      check(lk_pri_en_o, 0);
      da_pri_en_i = 1'b1;
      look({b_hi[15:0], b_lo});
      check(lk_w & 9'h1cf, 9'h184);
      $display("lookup end");
    end
  endtask
  task t_change;
    begin
      make(a_lo, {16'h0, a_hi[15:0]});
      look({a_hi[15:0], a_lo});
      check(lk_hit_o, 0);
      make(b_lo, 32'h01420b0a);
      look({b_hi[15:0], b_lo});
      check(lk_w, 9'h148);
      make(32'h0c0d0e10, 32'h01800f0f);
      sec;
      look(48'h0f0f_0c0d_0e10);
      check(lk_hit_o, 1);
      repeat (4) sec;
      look(48'h0f0f_0c0d_0e10);
      check(lk_hit_o, 0);
      look({b_hi[15:0], b_lo});
      check(lk_hit_o, 1);
      // source hit on a static entry must not learn its port
      lk_sa_i = {b_hi[15:0], b_lo};
      look({b_hi[15:0], b_lo});
      // source hit on a non-static entry restarts its age and learns the port
      lk_sa_i = 48'h0f0f_0c0d_0e10;
      make(32'h0c0d0e10, 32'h01800f0f);
      sec;
      look(48'h0f0f_0c0d_0e10);
      lk_sa_i = 48'h2;
      repeat (2) sec;
      look(48'h0f0f_0c0d_0e10);
      check(lk_w, 9'h104);
      look({b_hi[15:0], b_lo});
      check(lk_w, 9'h148);
      $display("change end");
    end
  endtask
  initial begin
    repeat (4) tick;
    reset_i = 1'b0;
    t_regs;
    t_walk;
    t_lookup;
    t_change;
    tally_and_finish;
  end
endmodule // tb_top
